// [logic/flash_host.sv]
// Host controller driving a byte-wide NOR flash through its strobe pins.
// Assumes the flash sits on the pins below; nrst marks power-up.
`timescale 1ns/100ps
module flash_host
    import flash_host_pkg::*;
#(
    parameter int PU_READ = PU_READ_CYC,
    parameter int PU_WRITE = PU_WRITE_CYC,
    parameter int POLL_LIMIT = 16000000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    output logic req_ready,
    output logic done,
    output logic timeout,
    output logic [DATA_W-1:0] rd_data,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output logic [DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe
);
    //----------------------------------------
    // State
    //----------------------------------------
    typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_GAP,
        ST_DONE} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] pu_cnt;
        logic [7:0] t_cnt;
        logic [CNT_W-1:0] poll_cnt;
        logic [2:0] op;
        logic [2:0] step;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic polling;
        logic have_prev;
        logic [DATA_W-1:0] prev;
        logic timeout;
        logic [DATA_W-1:0] rd;
        logic [ADDR_W-1:0] fa;
        logic [DATA_W-1:0] fd;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
    } state_t;
    state_t st_ff, nxt_st;

    // Number of bus writes for each operation
    function automatic logic [2:0] op_len(input logic [2:0] op);
        case (op)
            OP_PROGRAM: op_len = 3'h4;
            OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_LOCKOUT: op_len = 3'h6;
            OP_ID_ENTRY, OP_ID_EXIT: op_len = 3'h3;
            OP_ID_EXIT_SHORT: op_len = 3'h1;
            default: op_len = 3'h0;
        endcase
    endfunction

    // Address and byte of write number step; only 15 bits matter for commands
    function automatic logic [ADDR_W+DATA_W-1:0] cyc(input logic [2:0] op, input logic [2:0] step,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] ca;
        logic [DATA_W-1:0] cd;
        ca = {3'h0, CMD_ADDR_A};
        cd = CMD_UNLOCK1;
        if (op == OP_ID_EXIT_SHORT) begin
            ca = a;
            cd = CMD_ID_EXIT;
        end else begin
            case (step)
                3'h0: begin
                    cd = CMD_UNLOCK1;
                end
                3'h1, 3'h4: begin
                    ca = {3'h0, CMD_ADDR_B};
                    cd = CMD_UNLOCK2;
                end
                3'h2: begin
                    case (op)
                        OP_PROGRAM: cd = CMD_PROG;
                        OP_ID_ENTRY: cd = CMD_ID_ENTRY;
                        OP_ID_EXIT: cd = CMD_ID_EXIT;
                        default: cd = CMD_SETUP;
                    endcase
                end
                3'h3: begin
                    if (op == OP_PROGRAM) begin
                        ca = a;
                        cd = d;
                    end
                end
                3'h5: begin
                    case (op)
                        OP_CHIP_ERASE: cd = CMD_CHIP;
                        OP_SECTOR_ERASE: begin
                            ca = a;
                            cd = CMD_SECTOR;
                        end
                        default: cd = CMD_LOCK;
                    endcase
                end
                default: cd = CMD_UNLOCK1;
            endcase
        end
        cyc = {ca, cd};
    endfunction

    //----------------------------------------
    // Sequencer
    //----------------------------------------
    always_comb begin
        logic [ADDR_W+DATA_W-1:0] c;
        nxt_st = st_ff;
        c = cyc(st_ff.op, st_ff.step, st_ff.addr, st_ff.data);
        if (st_ff.pu_cnt != '0) begin
            nxt_st.pu_cnt = st_ff.pu_cnt - 1'b1;
        end
        if (st_ff.t_cnt != '0) begin
            nxt_st.t_cnt = st_ff.t_cnt - 1'b1;
        end
        case (st_ff.phase)
            ST_POWERUP: begin
                // Reads allowed before writes, but one wait covers both
                if (st_ff.pu_cnt == '0) begin
                    nxt_st.phase = ST_IDLE;
                end
            end
            ST_IDLE: begin
                nxt_st.timeout = 1'b0;
                if (req_valid) begin
                    nxt_st.op = req_op;
                    nxt_st.addr = req_addr;
                    nxt_st.data = req_data;
                    nxt_st.step = 3'h0;
                    nxt_st.have_prev = 1'b0;
                    nxt_st.poll_cnt = CNT_W'(POLL_LIMIT);
                    nxt_st.fa = req_addr;
                    nxt_st.ce_n = 1'b0;
                    nxt_st.t_cnt = 8'(STROBE_CYC);
                    if (req_op == OP_READ) begin
                        nxt_st.polling = 1'b0;
                        nxt_st.oe_n = 1'b0;
                        nxt_st.phase = ST_RD_LOW;
                    end else begin
                        nxt_st.phase = ST_WR_LOW;
                    end
                end
            end
            ST_WR_LOW: begin
                // Address and data held steady through the whole low pulse
                nxt_st.fa = c[DATA_W +: ADDR_W];
                nxt_st.fd = c[DATA_W-1:0];
                nxt_st.dq_oe = 1'b1;
                nxt_st.ce_n = 1'b0;
                nxt_st.we_n = 1'b0;
                if (st_ff.t_cnt == '0 && !st_ff.we_n) begin
                    nxt_st.we_n = 1'b1;
                    nxt_st.ce_n = 1'b1;
                    nxt_st.t_cnt = 8'(HIGH_CYC);
                    nxt_st.phase = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH: begin
                if (st_ff.t_cnt == '0) begin
                    nxt_st.dq_oe = 1'b0;
                    if (st_ff.step + 3'h1 == op_len(st_ff.op)) begin
                        // Embedded ops are polled until the byte toggle stops
                        if (st_ff.op == OP_PROGRAM || st_ff.op == OP_CHIP_ERASE ||
                            st_ff.op == OP_SECTOR_ERASE) begin
                            nxt_st.polling = 1'b1;
                            nxt_st.fa = st_ff.addr;
                            nxt_st.ce_n = 1'b0;
                            nxt_st.oe_n = 1'b0;
                            nxt_st.t_cnt = 8'(STROBE_CYC);
                            nxt_st.phase = ST_RD_LOW;
                        end else begin
                            nxt_st.phase = ST_DONE;
                        end
                    end else begin
                        nxt_st.step = st_ff.step + 3'h1;
                        nxt_st.t_cnt = 8'(STROBE_CYC);
                        nxt_st.phase = ST_WR_LOW;
                    end
                end
            end
            ST_RD_LOW: begin
                if (st_ff.t_cnt == '0) begin
                    nxt_st.rd = flash_dq_in;
                    nxt_st.oe_n = 1'b1;
                    nxt_st.ce_n = 1'b1;
                    nxt_st.t_cnt = 8'(HIGH_CYC);
                    nxt_st.phase = ST_RD_GAP;
                end
            end
            ST_RD_GAP: begin
                if (st_ff.t_cnt == '0) begin
                    nxt_st.phase = ST_DONE;
                    if (st_ff.polling) begin
                        nxt_st.have_prev = 1'b1;
                        nxt_st.prev = st_ff.rd;
                        nxt_st.poll_cnt = st_ff.poll_cnt - 1'b1;
                        // Busy while toggle bit alternates between reads
                        if (!st_ff.have_prev ||
                            (st_ff.prev[TOGGLE_BIT] != st_ff.rd[TOGGLE_BIT])) begin
                            if (st_ff.poll_cnt == '0) begin
                                nxt_st.timeout = 1'b1;
                            end else begin
                                nxt_st.ce_n = 1'b0;
                                nxt_st.oe_n = 1'b0;
                                nxt_st.t_cnt = 8'(STROBE_CYC);
                                nxt_st.phase = ST_RD_LOW;
                            end
                        end
                    end
                end
            end
            ST_DONE: begin
                nxt_st.phase = ST_IDLE;
            end
            default: nxt_st.phase = ST_IDLE;
        endcase
    end

    //----------------------------------------
    // Registers
    //----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.phase <= ST_POWERUP;
            // Longer of the two power-up waits, so neither can be cut short
            st_ff.pu_cnt <= CNT_W'((PU_WRITE > PU_READ) ? PU_WRITE : PU_READ);
            st_ff.ce_n <= 1'b1;
            st_ff.oe_n <= 1'b1;
            st_ff.we_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs
    assign req_ready = (st_ff.phase == ST_IDLE);
    assign done = (st_ff.phase == ST_DONE);
    assign timeout = st_ff.timeout;
    assign rd_data = st_ff.rd;
    assign flash_addr = st_ff.fa;
    assign flash_ce_n = st_ff.ce_n;
    assign flash_oe_n = st_ff.oe_n;
    assign flash_we_n = st_ff.we_n;
    assign flash_dq_out = st_ff.fd;
    assign flash_dq_oe = st_ff.dq_oe;

    //----------------------------------------
    // Assertions
    //----------------------------------------
    a_no_early_io: assert property (@(posedge clk) disable iff (!nrst)
        (st_ff.phase == ST_POWERUP) |-> (flash_we_n && flash_oe_n))
        else $error("bus used before power-up wait");
    a_no_contention: assert property (@(posedge clk) disable iff (!nrst)
        !(flash_dq_oe && !flash_oe_n))
        else $error("data driven while output enabled");
    a_we_oe_excl: assert property (@(posedge clk) disable iff (!nrst)
        !(!flash_we_n && !flash_oe_n))
        else $error("write and read strobes together");
    a_data_stable: assert property (@(posedge clk) disable iff (!nrst)
        (!flash_we_n && !$past(flash_we_n)) |-> $stable(flash_dq_out) && $stable(flash_addr))
        else $error("address or data moved during write pulse");
    a_unlock_first: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(flash_we_n) && st_ff.step == 3'h0 && st_ff.op != OP_ID_EXIT_SHORT) |->
        (flash_addr[14:0] == CMD_ADDR_A && flash_dq_out == CMD_UNLOCK1))
        else $error("first unlock write wrong");
    a_unlock_second: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(flash_we_n) && st_ff.step == 3'h1) |->
        (flash_addr[14:0] == CMD_ADDR_B && flash_dq_out == CMD_UNLOCK2))
        else $error("second unlock write wrong");
    a_short_exit: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(flash_we_n) && st_ff.op == OP_ID_EXIT_SHORT) |-> flash_dq_out == CMD_ID_EXIT)
        else $error("short exit byte wrong");
    a_poll_addr: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(flash_oe_n) && st_ff.polling) |-> flash_addr == st_ff.addr)
        else $error("poll read at wrong address");
    c_program: cover property (@(posedge clk) st_ff.op == OP_PROGRAM && done);
    c_sector: cover property (@(posedge clk) st_ff.op == OP_SECTOR_ERASE && done);
    c_id_exit: cover property (@(posedge clk) st_ff.op == OP_ID_EXIT_SHORT && done);
endmodule

// [logic/flash_host_pkg.sv]
// Constants for the parallel flash host controller.
// Assumes a byte-wide NOR flash with 18 address lines on the far side.
package flash_host_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 4;
    // Command addresses and bytes
    localparam logic [14:0] CMD_ADDR_A = 15'h5555;
    localparam logic [14:0] CMD_ADDR_B = 15'h2aaa;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_LOCK = 8'h40;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    // Host operation codes
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
    localparam logic [2:0] OP_LOCKOUT = 3'h4;
    localparam logic [2:0] OP_ID_ENTRY = 3'h5;
    localparam logic [2:0] OP_ID_EXIT = 3'h6;
    localparam logic [2:0] OP_ID_EXIT_SHORT = 3'h7;
    // Status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // Bus timing in ns, power-up waits in us and ms, all least times
    localparam int T_STROBE_NS = 120;
    localparam int T_HIGH_NS = 100;
    localparam int T_HOLD_NS = 50;
    localparam int T_PU_READ_US = 100;
    localparam int T_PU_WRITE_MS = 5;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PU_READ_CYC = T_PU_READ_US * 1000 / CLK_PERIOD_NS;
    localparam int PU_WRITE_CYC = T_PU_WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
endpackage

// [verification/flash_model.sv]
// Behavioural model of the byte-wide flash behind flash_host.
// Assumes only the host strobes; reacts to strobe edges, no clock.
`timescale 1ns/100ps
module flash_model #(
    parameter logic [7:0] MFR = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV = 8'h71 // Arbitrary value
) (
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe,
    output logic [7:0] flash_dq_in,
    input wire logic slow,
    input wire logic stuck
);
    logic [7:0] mem [0:262143];
    logic [17:0] a_lat;
    logic [7:0] last_d, last_q, d, q_drv;
    logic busy, prog_run, tog, id_mode, locked;
    int step;
    wire wr_act = !flash_ce_n && !flash_we_n;
    wire rd_act = !flash_ce_n && !flash_oe_n && flash_we_n;
    initial begin
        for (int i = 0; i < 262144; i++)
            mem[i] = 8'hff;
        {last_d, last_q, busy, prog_run, tog, id_mode, locked, step} = '0;
    end
    // Busy span; stuck holds it to provoke the host's poll limit
    task automatic run_busy(input int ns, input logic p);
        busy = 1'b1;
        prog_run = p;
        #(ns);
        wait (!stuck);
        busy = 1'b0;
    endtask
    task automatic erase(input int lo, input int hi, input int ns);
        for (int i = lo; i <= hi; i++)
            mem[i] = 8'hff;
        fork
            run_busy(ns, 1'b0);
        join_none
    endtask
    // Address on the later fall of the two strobes
    // Host may move the address on the very edge that lowers the strobe; look just after it
    always @(posedge wr_act) begin
        #1;
        a_lat = flash_addr;
    end
    // Data and command on the earlier rise
    always @(negedge wr_act) begin
        d = flash_dq_oe ? flash_dq_out : ~last_q;
        if (busy) begin
            step = 0;
        end else if (d == 8'hf0 && step != 3) begin
            id_mode = 1'b0;
            step = 0;
        end else begin
            case (step)
                0, 4: step = (d == 8'haa && a_lat[14:0] == 15'h5555) ? step + 1 : 0;
                1, 5: step = (d == 8'h55 && a_lat[14:0] == 15'h2aaa) ? step + 1 : 0;
                2: begin
                    step = (a_lat[14:0] != 15'h5555) ? 0 : (d == 8'ha0) ? 3 : (d == 8'h80) ? 4 : 0;
                    id_mode = id_mode | (a_lat[14:0] == 15'h5555 && d == 8'h90);
                end
                3: begin
                    step = 0;
                    last_d = d;
                    mem[a_lat] = mem[a_lat] & d;
                    fork
                        run_busy(slow ? 2000 : 300, 1'b1);
                    join_none
                end
                default: begin
                    step = 0;
                    if (d == 8'h10 && a_lat[14:0] == 15'h5555)
                        erase(0, 262143, slow ? 2000 : 300);
                    else if (d == 8'h40 && a_lat[14:0] == 15'h5555)
                        locked = 1'b1;
                    else if (d == 8'h30 && a_lat >= 18'h3c000)
                        erase(locked ? 1 : 'h3c000, locked ? 0 : 'h3ffff, locked ? 100 : 300);
                    else if (d == 8'h30 && a_lat >= 18'h3a000)
                        erase('h3a000, 'h3bfff, 300);
                    else if (d == 8'h30 && a_lat >= 18'h38000)
                        erase('h38000, 'h39fff, 300);
                    else if (d == 8'h30 && a_lat >= 18'h20000)
                        erase('h20000, 'h37fff, 300);
                    else if (d == 8'h30)
                        erase(0, 'h1ffff, 300);
                end
            endcase
        end
    end
    // Toggle advances once per read access while busy
    always @(posedge rd_act)
        tog = busy ? ~tog : tog;
    // Driven byte kept apart from the pins, so the release edge never races the bus
    always_comb begin
        if (busy)
            q_drv = {prog_run & ~last_d[7], tog, 6'h2a};
        else if (id_mode)
            q_drv = flash_addr[0] ? DEV : MFR;
        else
            q_drv = mem[flash_addr];
    end
    always @(negedge rd_act)
        last_q = q_drv;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign flash_dq_in = rd_act ? q_drv : ~last_q;
endmodule

// [verification/tb_top.sv]
// Self-checking bench for flash_host against a behavioural flash.
// Assumes flash_model.sv and the design files are compiled first.
`timescale 1ns/100ps
module tb_top;
    import flash_host_pkg::*;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEV = 8'h71; // Arbitrary value
    logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, slow = 1'b0, stuck = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [17:0] req_addr = 18'h0, a;
    logic [7:0] req_data = 8'h0, rd_data, dq_in, dq_out;
    logic req_ready, done, timeout, ce_n, oe_n, we_n, dq_oe;
    logic [17:0] f_addr;
    int fail_count = 0, checks_done = 0, ref_id = 0, ref_lock = 0;
    int ref_mem [int];
    logic [17:0] spot [5] = '{18'h3c123, 18'h3a456, 18'h38789, 18'h2abcd, 18'h05432};
    logic [17:0] lo [5] = '{18'h3c000, 18'h3a000, 18'h38000, 18'h20000, 18'h00000};
    logic [17:0] hi [5] = '{18'h3ffff, 18'h3bfff, 18'h39fff, 18'h37fff, 18'h1ffff};
    always #2 clk = ~clk;
    flash_host #(.PU_READ(10), .PU_WRITE(20), .POLL_LIMIT(50)) DUT (.clk(clk), .nrst(nrst), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .done(done),
        .timeout(timeout), .rd_data(rd_data), .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
    flash_model #(.MFR(MFR), .DEV(DEV)) far_end (.flash_addr(f_addr), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .flash_dq_in(dq_in), .slow(slow), .stuck(stuck));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s flag %b", $time, what, got);
        end
    endtask
    function automatic logic [7:0] ref_rd(input int x);
        return ref_id ? ((x & 1) ? DEV : MFR) : ref_mem.exists(x) ? ref_mem[x][7:0] : 8'hff;
    endfunction
    // One request; called and left at 1 ns after an edge
    task automatic do_op(input logic [2:0] op, input logic [17:0] ad, input logic [7:0] dt);
        int n;
        {req_op, req_addr, req_data} = {op, ad, dt};
        for (n = 0; req_ready !== 1'b1 && n < 2000; n++)
            @(posedge clk) #1;
        cmp1(req_ready, 1'b1, "ready");
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (n = 0; done !== 1'b1 && n < 8000; n++)
            @(posedge clk) #1;
        cmp1(done, 1'b1, "completion");
    endtask
    task automatic rd(input logic [17:0] ad);
        do_op(OP_READ, ad, 8'h00);
        cmp8(rd_data, ref_rd(ad), "read");
        cmp1(timeout, 1'b0, "read timeout");
    endtask
    task automatic prog(input logic [17:0] ad, input logic [7:0] dt);
        ref_mem[ad] = ref_rd(ad) & dt;
        do_op(OP_PROGRAM, ad, dt);
        cmp1(timeout, stuck, "program timeout");
        if (!stuck)
            cmp8(rd_data, ref_rd(ad), "program");
    endtask
    task automatic erase_at(input int i);
        int ks[$];
        a = lo[i] + 18'($urandom_range(int'(hi[i] - lo[i])));
        foreach (ref_mem[k])
            if (k >= lo[i] && k <= hi[i] && !(i == 0 && ref_lock))
                ks.push_back(k);
        foreach (ks[k])
            ref_mem.delete(ks[k]);
        do_op(OP_SECTOR_ERASE, a, 8'h00);
        cmp8(rd_data, ref_rd(a), "sector erase");
        for (int j = 0; j < 5; j++)
            rd(spot[j]);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        #(CLK_PERIOD_NS * 60000);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out;
    end
    // Main sequence
    initial begin
        void'($urandom(32'h517b));
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        cmp1(req_ready, 1'b0, "ready during power-up");
        for (int i = 0; i < 6; i++) begin
            slow = i[0];
            a = 18'($urandom_range(32'h37fff));
            rd(a);
            prog(a, 8'($urandom));
            prog(a, 8'($urandom));
        end
        for (int e = 0; e < 2; e++) begin
            do_op(OP_ID_ENTRY, 18'h0, 8'h00);
            ref_id = 1;
            rd(18'h0);
            rd(18'h1);
            do_op(e ? OP_ID_EXIT_SHORT : OP_ID_EXIT, a, 8'h00);
            ref_id = 0;
            rd(a);
        end
        for (int i = 0; i < 5; i++)
            prog(spot[i], 8'($urandom));
        for (int i = 0; i < 5; i++)
            erase_at(i);
        for (int i = 0; i < 5; i++)
            prog(spot[i], 8'h00);
        do_op(OP_CHIP_ERASE, 18'h0, 8'h00);
        ref_mem.delete();
        cmp8(rd_data, 8'hff, "chip erase");
        rd(spot[2]);
        prog(spot[0], 8'h00);
        do_op(OP_LOCKOUT, 18'h0, 8'h00);
        ref_lock = 1;
        erase_at(0);
        erase_at(3);
        stuck = 1'b1;
        prog(spot[4], 8'h0f);
        stuck = 1'b0;
        rd(spot[4]);
        close_out;
    end
endmodule
